// ==== logic/spc_pkg.sv ====
// Function
// - lock mode A0h then 0000h sets lock if cfg clear
// - lock mode 90h then 0000h, or 00F0h, exits
// - lock mode 70h@555h reads status once; 71h clears
// - volatile mode A0h then 0000h sets, 0001h clears
// - volatile mode 70h@555h reads status once; 71h clears
// - volatile mode 90h then 0000h, or 00F0h, exits
package spc_pkg;

   // apb byte offsets
   localparam logic [7:0] OFF_CMD_ADDR = 8'h00;
   localparam logic [7:0] OFF_CMD_DATA = 8'h04;
   localparam logic [7:0] OFF_READ_DATA = 8'h08;
   localparam logic [7:0] OFF_STATE = 8'h0c;
   localparam logic [7:0] OFF_LOCK_CFG = 8'h10;
   localparam logic [7:0] OFF_GLOBAL_LOCK = 8'h14;
   localparam logic [7:0] OFF_VOLATILE = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1c;
   localparam logic [7:0] OFF_MODE_ENTER = 8'h20;

   // command codes
   localparam logic [15:0] CMD_SW_RESET = 16'h00f0;
   localparam logic [7:0] CMD_STATUS_ENTER = 8'h70;
   localparam logic [7:0] CMD_STATUS_CLEAR = 8'h71;
   localparam logic [7:0] CMD_EXIT_ENTRY = 8'h90;
   localparam logic [15:0] CMD_EXIT = 16'h0000;
   localparam logic [7:0] CMD_PROG_ENTRY = 8'ha0;
   localparam logic [15:0] CMD_SET = 16'h0000;
   localparam logic [15:0] CMD_CLEAR = 16'h0001;
   localparam logic [11:0] CMD_ADDR_555 = 12'h555;

   // mode entry codes
   localparam logic [1:0] MODE_GLOBAL = 2'h1;
   localparam logic [1:0] MODE_VOLATILE = 2'h2;

   // lock config and status fields
   localparam int LOCK_CFG_BIT_A = 2;
   localparam int LOCK_CFG_BIT_B = 5;
   localparam int STAT_READY = 7;
   localparam int STAT_PROG_FAIL = 4;
   localparam logic [7:0] LOCK_CFG_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h80;
   localparam logic [7:0] STATUS_CLEARED = 8'h80;

   // sectors
   localparam int SECTORS = 16;
   localparam int SEC_W = 4;
   localparam int SEC_LSB = 16;
   localparam logic [31:0] ARRAY_FILL = 32'h0000ffff;

   typedef enum logic [3:0] {
      st_array_read,
      st_global_lock_mode,
      st_global_lock_status_read,
      st_global_lock_set_pending,
      st_global_lock_exit_pending,
      st_volatile_sector_protect,
      st_volatile_protect_status_read,
      st_volatile_protect_setclear_pending,
      st_volatile_protect_exit_pending
   } spc_state_t;

endpackage : spc_pkg

// ==== logic/spc_sector_bits.sv ====
`timescale 1ns/1ns
module spc_sector_bits
   import spc_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // update request
   input wire logic set_en,
   input wire logic clr_en,
   input wire logic [SEC_W-1:0] sector,
   // protection state
   output logic [SECTORS-1:0] bits
);

   typedef struct packed {
      logic [SECTORS-1:0] bits;
   } spc_bits_t;

   spc_bits_t r;
   spc_bits_t next_r;

   always_comb
   begin
      next_r = r;
      if (set_en)
      begin
         next_r.bits[sector] = 1'b1;
      end
      else if (clr_en)
      begin
         next_r.bits[sector] = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r <= '0;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign bits = r.bits;

endmodule : spc_sector_bits

// ==== logic/spc_cmd_fsm.sv ====
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ns
module spc_cmd_fsm
   import spc_pkg::*;
(
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // protection state
   output logic global_lock,
   output logic [SECTORS-1:0] volatile_protect
);

   typedef struct packed {
      spc_state_t state;
      logic [31:0] cmd_addr;
      logic [7:0] lock_cfg;
      logic global_lock;
      logic [7:0] status;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } spc_ctl_t;

   spc_ctl_t r;
   spc_ctl_t next_r;
   logic access;
   logic cmd_wr;
   logic data_rd;
   logic [15:0] cmd_d;
   logic sec_set;
   logic sec_clr;
   logic [SEC_W-1:0] sec_idx;
   logic [SECTORS-1:0] sec_bits;

   function automatic logic low_is(input logic [15:0] d, input logic [7:0] code);
      return d[7:0] == code;
   endfunction : low_is

   function automatic logic at_555(input logic [31:0] a);
      return a[11:0] == CMD_ADDR_555;
   endfunction : at_555

   function automatic logic lock_cfg_clear(input logic [7:0] c);
      return !c[LOCK_CFG_BIT_A] && !c[LOCK_CFG_BIT_B];
   endfunction : lock_cfg_clear

   assign access = psel && penable && !r.pready;
   assign cmd_wr = access && pwrite && paddr[7:0] == OFF_CMD_DATA;
   assign data_rd = access && !pwrite && paddr[7:0] == OFF_READ_DATA;
   assign cmd_d = pwdata[15:0];
   assign sec_idx = r.cmd_addr[SEC_LSB +: SEC_W];

   always_comb
   begin
      next_r = r;
      next_r.pready = 1'b0;
      next_r.pslverr = 1'b0;
      sec_set = 1'b0;
      sec_clr = 1'b0;
      if (access)
      begin
         next_r.pready = 1'b1;
         next_r.prdata = '0;
         if (pwrite)
         begin
            unique case (paddr[7:0])
               OFF_CMD_ADDR: next_r.cmd_addr = pwdata;
               OFF_LOCK_CFG: next_r.lock_cfg = pwdata[7:0];
               OFF_MODE_ENTER:
               begin
                  if (r.state == st_array_read && pwdata[1:0] == MODE_GLOBAL)
                  begin
                     next_r.state = st_global_lock_mode;
                  end
                  else if (r.state == st_array_read && pwdata[1:0] == MODE_VOLATILE)
                  begin
                     next_r.state = st_volatile_sector_protect;
                  end
               end
               OFF_CMD_DATA:
               begin
                  // anything not matched below leaves state alone
                  unique case (r.state)
                     st_global_lock_mode, st_volatile_sector_protect:
                     begin
                        if (cmd_d == CMD_SW_RESET)
                        begin
                           next_r.state = st_array_read;
                        end
                        else if (low_is(cmd_d, CMD_STATUS_ENTER) && at_555(r.cmd_addr))
                        begin
                           next_r.state = (r.state == st_global_lock_mode) ? st_global_lock_status_read
                                          : st_volatile_protect_status_read;
                        end
                        else if (low_is(cmd_d, CMD_STATUS_CLEAR) && at_555(r.cmd_addr))
                        begin
                           next_r.status = STATUS_CLEARED;
                        end
                        else if (low_is(cmd_d, CMD_EXIT_ENTRY))
                        begin
                           next_r.state = (r.state == st_global_lock_mode) ? st_global_lock_exit_pending
                                          : st_volatile_protect_exit_pending;
                        end
                        else if (low_is(cmd_d, CMD_PROG_ENTRY))
                        begin
                           next_r.state = (r.state == st_global_lock_mode) ? st_global_lock_set_pending
                                          : st_volatile_protect_setclear_pending;
                        end
                     end
                     st_global_lock_set_pending:
                     begin
                        if (cmd_d == CMD_SET && lock_cfg_clear(r.lock_cfg))
                        begin
                           next_r.global_lock = 1'b1;
                           next_r.state = st_global_lock_mode;
                        end
                        else if (cmd_d == CMD_SET)
                        begin
                           next_r.status[STAT_PROG_FAIL] = 1'b1;
                        end
                     end
                     st_volatile_protect_setclear_pending:
                     begin
                        if (cmd_d == CMD_SET || cmd_d == CMD_CLEAR)
                        begin
                           sec_set = cmd_d == CMD_SET;
                           sec_clr = cmd_d == CMD_CLEAR;
                           next_r.state = st_volatile_sector_protect;
                        end
                     end
                     st_global_lock_exit_pending, st_volatile_protect_exit_pending:
                     begin
                        if (cmd_d == CMD_EXIT)
                        begin
                           next_r.state = st_array_read;
                        end
                     end
                     st_array_read, st_global_lock_status_read, st_volatile_protect_status_read:
                     begin
                        next_r.state = r.state;
                     end
                  endcase
               end
               default: next_r.pslverr = 1'b1;
            endcase
         end
         else
         begin
            unique case (paddr[7:0])
               OFF_CMD_ADDR: next_r.prdata = r.cmd_addr;
               OFF_STATE: next_r.prdata = {28'h0000000, r.state};
               OFF_LOCK_CFG: next_r.prdata = {24'h000000, r.lock_cfg};
               OFF_GLOBAL_LOCK: next_r.prdata = {31'h00000000, r.global_lock};
               OFF_VOLATILE: next_r.prdata = {16'h0000, sec_bits};
               OFF_STATUS: next_r.prdata = {24'h000000, r.status};
               OFF_CMD_DATA, OFF_MODE_ENTER: next_r.prdata = '0;
               OFF_READ_DATA:
               begin
                  unique case (r.state)
                     st_global_lock_status_read:
                     begin
                        next_r.prdata = {24'h000000, r.status};
                        next_r.state = st_global_lock_mode;
                     end
                     st_volatile_protect_status_read:
                     begin
                        next_r.prdata = {24'h000000, r.status};
                        next_r.state = st_volatile_sector_protect;
                     end
                     st_global_lock_mode, st_global_lock_set_pending, st_global_lock_exit_pending:
                     begin
                        next_r.prdata = {31'h00000000, r.global_lock};
                     end
                     st_volatile_sector_protect, st_volatile_protect_setclear_pending,
                     st_volatile_protect_exit_pending:
                     begin
                        next_r.prdata = {31'h00000000, sec_bits[sec_idx]};
                     end
                     st_array_read: next_r.prdata = ARRAY_FILL;
                  endcase
               end
               default: next_r.pslverr = 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r.state <= st_array_read;
         r.cmd_addr <= '0;
         r.lock_cfg <= LOCK_CFG_RESET;
         r.global_lock <= 1'b0;
         r.status <= STATUS_RESET;
         r.prdata <= '0;
         r.pready <= 1'b0;
         r.pslverr <= 1'b0;
      end
      else
      begin
         r <= next_r;
      end
   end

   spc_sector_bits u_bits (
      .pclk(pclk),
      .presetn(presetn),
      .set_en(sec_set),
      .clr_en(sec_clr),
      .sector(sec_idx),
      .bits(sec_bits)
   );

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign global_lock = r.global_lock;
   assign volatile_protect = sec_bits;

   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_LOCK_ARM: assert property (
      r.state == st_global_lock_mode && cmd_wr && low_is(cmd_d, CMD_PROG_ENTRY)
      |=> r.state == st_global_lock_set_pending)
      else $error("lock program entry missed");
   AST_LOCK_SET: assert property (
      r.state == st_global_lock_set_pending && cmd_wr && cmd_d == CMD_SET && lock_cfg_clear(r.lock_cfg)
      |=> r.global_lock && r.state == st_global_lock_mode)
      else $error("lock bit not set");
   AST_LOCK_GUARD: assert property (
      $rose(r.global_lock) |-> lock_cfg_clear($past(r.lock_cfg)))
      else $error("lock bit set while config bits high");
   AST_GL_EXIT: assert property (
      r.state == st_global_lock_exit_pending && cmd_wr && cmd_d == CMD_EXIT
      |=> r.state == st_array_read)
      else $error("lock mode exit failed");
   AST_GL_STATUS: assert property (
      r.state == st_global_lock_status_read && data_rd
      |=> r.prdata[7:0] == r.status && r.state == st_global_lock_mode && r.pready)
      else $error("lock status read wrong");
   AST_VP_UPDATE: assert property (
      r.state == st_volatile_protect_setclear_pending && cmd_wr && (cmd_d == CMD_SET || cmd_d == CMD_CLEAR)
      |=> sec_bits[$past(sec_idx)] == ($past(cmd_d) == CMD_SET) && r.state == st_volatile_sector_protect)
      else $error("sector bit update wrong");
   AST_VP_STATUS: assert property (
      r.state == st_volatile_protect_status_read && data_rd
      |=> r.prdata[7:0] == r.status ##1 r.state == st_volatile_sector_protect)
      else $error("volatile status read wrong");
   AST_VP_EXIT: assert property (
      r.state == st_volatile_sector_protect && cmd_wr && low_is(cmd_d, CMD_EXIT_ENTRY)
      |=> r.state == st_volatile_protect_exit_pending)
      else $error("volatile exit entry missed");
   AST_IGNORE: assert property (
      !access |=> $stable(r.state) && $stable(r.global_lock) && $stable(sec_bits))
      else $error("state moved without a command");
   AST_SR_HOLD: assert property (
      r.state == st_global_lock_status_read && cmd_wr |=> r.state == st_global_lock_status_read)
      else $error("status read state left on write");
   AST_LOCK_BLOCK: assert property (
      r.state == st_global_lock_set_pending && cmd_wr && !lock_cfg_clear(r.lock_cfg)
      |=> r.state == st_global_lock_set_pending && $stable(r.global_lock))
      else $error("lock set not blocked by config bits");
   AST_GL_EXIT_ARM: assert property (
      r.state == st_global_lock_mode && cmd_wr && low_is(cmd_d, CMD_EXIT_ENTRY)
      |=> r.state == st_global_lock_exit_pending)
      else $error("lock exit entry missed");
   AST_SW_RESET: assert property (
      (r.state == st_global_lock_mode || r.state == st_volatile_sector_protect) && cmd_wr && cmd_d == CMD_SW_RESET
      |=> r.state == st_array_read)
      else $error("software reset did not reach array read");
   AST_GL_STAT_ENTER: assert property (
      r.state == st_global_lock_mode && cmd_wr && low_is(cmd_d, CMD_STATUS_ENTER) && at_555(r.cmd_addr)
      |=> r.state == st_global_lock_status_read)
      else $error("lock status entry missed");
   AST_STAT_CLEAR: assert property (
      (r.state == st_global_lock_mode || r.state == st_volatile_sector_protect) && cmd_wr
      && low_is(cmd_d, CMD_STATUS_CLEAR) && at_555(r.cmd_addr) |=> r.status == STATUS_CLEARED && $stable(r.state))
      else $error("status clear wrong");
   AST_VP_ARM: assert property (
      r.state == st_volatile_sector_protect && cmd_wr && low_is(cmd_d, CMD_PROG_ENTRY)
      |=> r.state == st_volatile_protect_setclear_pending)
      else $error("volatile program entry missed");
   AST_VP_EXIT_DONE: assert property (
      r.state == st_volatile_protect_exit_pending && cmd_wr && cmd_d == CMD_EXIT
      |=> r.state == st_array_read)
      else $error("volatile mode exit failed");

   COV_LOCK_SET: cover property (r.state == st_global_lock_set_pending ##1 $rose(r.global_lock));
   COV_VP_CLEAR: cover property (r.state == st_volatile_protect_setclear_pending && cmd_wr && cmd_d == CMD_CLEAR);
   COV_GL_STATUS: cover property (r.state == st_global_lock_status_read ##1 r.state == st_global_lock_mode);
   COV_EXIT: cover property (r.state == st_volatile_protect_exit_pending ##1 r.state == st_array_read);

endmodule : spc_cmd_fsm

// ==== tb/spc_host_model.sv ====
`timescale 1ns/1ns
module spc_host_model (
   // clock
   input wire logic pclk,
   // apb request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] paddr,
   output logic [31:0] pwdata,
   // apb answer
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
   end

   // one whole bus cycle; command data rides in pwdata[15:0]
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err, output logic to);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      to = (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines must not keep the last value
      paddr <= ~paddr;
      pwdata <= ~pwdata;
   endtask : xfer
endmodule : spc_host_model

// ==== tb/tb.sv ====
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb;
   import spc_pkg::*;
   typedef struct {logic [1:0] k; logic [31:0] a; logic [31:0] d; logic [3:0] st;} spc_row_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, global_lock;
   logic [31:0] paddr, pwdata, prdata;
   logic [SECTORS-1:0] volatile_protect;
   int failures = 0;
   int num_checks = 0;
   // kind 0 mode enter, 1 command at address, 2 data read expecting d; then state st
   spc_row_t rows [30] = '{
      '{2'h0, 32'h0, 32'h1, 4'h1}, '{2'h1, 32'h555, 32'h70, 4'h2},
      '{2'h2, 32'h0, 32'h80, 4'h1}, '{2'h1, 32'h555, 32'h71, 4'h1},
      '{2'h1, 32'h0, 32'h70, 4'h1}, '{2'h1, 32'h0, 32'ha0, 4'h3},
      '{2'h1, 32'h0, 32'h1, 4'h3}, '{2'h1, 32'h0, 32'h0, 4'h1},
      '{2'h2, 32'h0, 32'h1, 4'h1}, '{2'h1, 32'h0, 32'h90, 4'h4},
      '{2'h2, 32'h0, 32'h1, 4'h4}, '{2'h1, 32'h0, 32'h0, 4'h0},
      '{2'h0, 32'h0, 32'h1, 4'h1}, '{2'h1, 32'h0, 32'hf0, 4'h0},
      '{2'h0, 32'h0, 32'h2, 4'h5}, '{2'h1, 32'h30000, 32'ha0, 4'h7},
      '{2'h1, 32'h30000, 32'h0, 4'h5}, '{2'h2, 32'h0, 32'h1, 4'h5},
      '{2'h1, 32'h555, 32'h70, 4'h6}, '{2'h2, 32'h0, 32'h80, 4'h5},
      '{2'h1, 32'h555, 32'h71, 4'h5}, '{2'h1, 32'h0, 32'h90, 4'h8},
      '{2'h2, 32'h0, 32'h0, 4'h8}, '{2'h1, 32'h0, 32'h0, 4'h0},
      '{2'h0, 32'h0, 32'h2, 4'h5}, '{2'h1, 32'h30000, 32'ha0, 4'h7},
      '{2'h1, 32'h30000, 32'h1, 4'h5}, '{2'h2, 32'h0, 32'h0, 4'h5},
      '{2'h1, 32'h0, 32'hf0, 4'h0}, '{2'h2, 32'h0, 32'hffff, 4'h0}};

   always #50 pclk = ~pclk;

   spc_host_model spc_host_model_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   spc_cmd_fsm spc_cmd_fsm_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .global_lock(global_lock), .volatile_protect(volatile_protect));

   task automatic test_done;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done

   task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
      logic t;
      spc_host_model_i.xfer(w, a, d, r, e, t);
      if (t)
      begin
         failures++;
         $display("transfer timed out");
         test_done();
      end
   endtask : xf

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      xf(1'b1, a, d, r, e);
   endtask : wr

   task automatic cmd(input logic [31:0] a, input logic [31:0] d);
      wr(OFF_CMD_ADDR, a);
      wr(OFF_CMD_DATA, d);
   endtask : cmd

   task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      logic [31:0] r;
      logic er;
      xf(1'b0, a, 32'h0, r, er);
      `CHK(nm, e, r)
   endtask : chk_rd

   task automatic do_reset;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
   endtask : do_reset

   initial
   begin
      logic [31:0] r;
      logic e;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      chk_rd(OFF_STATE, 32'h0, "reset state");
      chk_rd(OFF_STATUS, {24'h0, STATUS_RESET}, "reset status");
      chk_rd(OFF_LOCK_CFG, 32'h0, "reset lock cfg");
      chk_rd(OFF_GLOBAL_LOCK, 32'h0, "reset global lock");
      chk_rd(OFF_VOLATILE, 32'h0, "reset volatile");
      xf(1'b0, 8'h24, 32'h0, r, e);
      `CHK("unmapped err", 1'b1, e)
      `CHK("unmapped data", 32'h0, r)
      $display("reset test done");
      foreach (rows[i])
      begin
         case (rows[i].k)
            2'h0: wr(OFF_MODE_ENTER, rows[i].d);
            2'h1: cmd(rows[i].a, rows[i].d);
            default: chk_rd(OFF_READ_DATA, rows[i].d, "read data");
         endcase
         chk_rd(OFF_STATE, {28'h0, rows[i].st}, "state");
      end
      `CHK("global lock pin", 1'b1, global_lock)
      `CHK("volatile pins", 16'h0, volatile_protect)
      $display("table test done");
      do_reset();
      `CHK("lock after reset", 1'b0, global_lock)
      wr(OFF_LOCK_CFG, 32'h04);
      wr(OFF_MODE_ENTER, 32'h1);
      cmd(32'h0, 32'ha0);
      cmd(32'h0, 32'h0);
      chk_rd(OFF_STATE, 32'h3, "blocked by cfg 2");
      `CHK("lock blocked", 1'b0, global_lock)
      wr(OFF_LOCK_CFG, 32'h20);
      cmd(32'h0, 32'h0);
      chk_rd(OFF_STATE, 32'h3, "blocked by cfg 5");
      wr(OFF_LOCK_CFG, 32'h0);
      cmd(32'h0, 32'h0);
      chk_rd(OFF_STATE, 32'h1, "set after cfg clear");
      `CHK("lock set", 1'b1, global_lock)
      chk_rd(OFF_STATUS, 32'h90, "status program fail");
      cmd(32'h555, 32'h70);
      cmd(32'h0, 32'hf0);
      chk_rd(OFF_STATE, 32'h2, "status read ignores write");
      chk_rd(OFF_READ_DATA, 32'h90, "status read fail bit");
      chk_rd(OFF_STATE, 32'h1, "back to lock mode");
      cmd(32'h555, 32'h71);
      chk_rd(OFF_STATUS, 32'h80, "status cleared");
      $display("lock config test done");
      cmd(32'h0, 32'hf0);
      wr(OFF_MODE_ENTER, 32'h2);
      cmd(32'hf0000, 32'ha0);
      cmd(32'hf0000, 32'h0);
      `CHK("top sector", 16'h8000, volatile_protect)
      chk_rd(OFF_VOLATILE, 32'h8000, "volatile reg");
      cmd(32'h0, 32'h90);
      cmd(32'h0, 32'ha0);
      chk_rd(OFF_STATE, 32'h8, "exit pend ignores");
      cmd(32'h0, 32'h0);
      chk_rd(OFF_STATE, 32'h0, "exit done");
      $display("sector test done");
      test_done();
   end
endmodule : tb
